//--- rtl/adcr_pkg.sv
// shared constants, modes and carriers of the converter control register block
package adcr_pkg;
  // ==========================================================================
  // address map
  localparam logic [9:0] ADDR_RAM_LAST = 10'h0FF;
  localparam logic [9:0] ADDR_CTRL1 = 10'h100;
  localparam logic [9:0] ADDR_CTRL2 = 10'h101;
  localparam logic [9:0] ADDR_VOL_FIRST = 10'h102;
  localparam logic [9:0] ADDR_VOL_LAST = 10'h109;
  localparam logic [9:0] ADDR_SAFE_FIRST = 10'h112;
  localparam logic [9:0] ADDR_SAFE_LAST = 10'h116;
  // ==========================================================================
  // field positions
  localparam int C1_CAP_LO = 12;
  localparam int C1_HALT = 10;
  localparam int C1_SAFE = 9;
  localparam int C1_MUTE = 7;
  localparam int C1_PDN = 6;
  localparam int C1_DEEMPH_LO = 4;
  localparam int C1_FMT_LO = 2;
  localparam int C1_WLEN_LO = 0;
  localparam int C2_RAMP_SLOW = 9;
  localparam int C2_SOUT_EN = 8;
  localparam int C2_SIN_LO = 6;
  localparam int C2_MCLK_LO = 4;
  localparam int C2_MCLK_256 = 2;
  localparam int C2_MOUT_LO = 0;
  localparam int ST_SAFE = 0;
  localparam int ST_HALT = 1;
  localparam int SAFE_DATA_LO = 0;
  localparam int SAFE_ADDR_LO = 22;
  // ==========================================================================
  // reset values and storable bits
  localparam logic [13:0] CTRL1_RESET = 14'h0000;
  localparam logic [9:0] CTRL2_RESET = 10'h000;
  localparam logic [13:0] CTRL1_MASK = 14'h34FF;
  localparam logic [9:0] CTRL2_MASK = 10'h3F7;
  localparam logic [21:0] VOL_UNITY = 22'h10_0000;
  localparam logic [21:0] VOL_HALF = 22'h08_0000;
  localparam logic [21:0] VOL_MAX_INT = 22'h3F_FFFF;
  localparam logic [21:0] HOLD_ONE = 22'h00_0001;
  // ==========================================================================
  // ramp timing in frame-clock periods for the full +2.0 to 0 span
  localparam int FULL_SPAN = 2097152;
  localparam int FULL_RAMP_FAST = 1024;
  localparam int FULL_RAMP_SLOW = 8192;
  localparam logic [21:0] STEP_FAST = 22'(FULL_SPAN / FULL_RAMP_FAST);
  localparam logic [21:0] STEP_SLOW = 22'(FULL_SPAN / FULL_RAMP_SLOW);
  // ==========================================================================
  // memory layout
  localparam int VOL_NUM = 8;
  localparam int SAFE_NUM = 5;
  localparam int PRAM_DEPTH = 256;
  localparam int BIQUAD_WORDS = 110;
  localparam int BIQUAD_COEFS = 5;
  localparam int MAIN_TABLE_LO = 110;
  localparam int MAIN_TABLE_HI = 142;
  localparam int MAIN_GAIN = 144;
  localparam int SUB_TABLE_LO = 145;
  localparam int SUB_TABLE_HI = 177;
  localparam int SUB_GAIN = 179;
  localparam int SUB_FEED_L = 189;
  localparam int SUB_FEED_R = 190;
  localparam int HOLD_MAIN = 191;
  localparam int HOLD_SUB = 192;
  localparam int DECAY_MAIN = 193;
  localparam int DECAY_SUB = 194;
  // ==========================================================================
  // modes
  typedef enum logic [1:0] {CAP_NONE, CAP_TDM6, CAP_STEREO, CAP_UNUSED} adcr_capture_type;
  typedef enum logic [1:0] {DE_OFF, DE_44K1, DE_32K, DE_48K} adcr_deemph_type;
  typedef enum logic [1:0] {FMT_I2S, FMT_RJ, FMT_DSP, FMT_LJ} adcr_format_type;
  typedef enum logic [1:0] {WL_24, WL_20, WL_16} adcr_wlen_type;
  typedef enum logic [1:0] {MO_OFF, MO_CORE, MO_HALF, MO_THRU} adcr_mout_type;
  // ==========================================================================
  // carriers
  typedef struct packed {
    logic valid;
    logic write;
    logic [9:0] addr;
    logic [29:0] data;
  } adcr_req_type;
  typedef struct packed {
    logic valid;
    logic [23:0] data;
  } adcr_rsp_type;
  typedef struct packed {
    adcr_capture_type capture;
    adcr_deemph_type deemph;
    adcr_format_type format;
    adcr_wlen_type wlen;
    logic mute;
    logic powerdown;
    logic halt;
    logic core_doubler;
    logic ramp_slow;
  } adcr_mode_type;
endpackage : adcr_pkg

//--- rtl/adcr_control_regs.sv
// control, status, volume and parameter memory logic of the converter
//
// Overview of operation
// - control one bits 13:12 pick capture output: none, six-slot, two-channel, unused
// - halt bit ramps volume down, then stops the processing core
// - safe transfer bit requests copying pending safe-load pairs into parameter memory
// - soft mute bit starts a gradual ramp of output volume down to zero
// - soft power-down bit puts the processing core into power-down
// - bits 5:4 select de-emphasis: off, 44.1 kHz, 32 kHz, 48 kHz
// - bits 3:2 select input format: I2S, right-justified, DSP, left-justified
// - bits 1:0 select word length: 24, 20, or 16 bits for both upper codes
// - control two bits 1:0 drive clock output: off, core, half core, feed-through
// - half-rate clock output is inverted; feed-through output is not
// - control two bit 2 chooses direct 512fs clock or doubled 256fs clock
// - bits 5:4 select one of three master clock inputs; code 11 unused
// - bits 7:6 select one of three serial input ports with data and clocks
// - bit 8 enables three serial output pins carrying the selected input
// - bit 9 sets full ramp to 1024 or 8192 frame-clock periods
// - status bit 0 sets when safe-load copy finishes, clears after status read
// - status bit 1 sets once the requested core shutdown has finished
// - eight 22-bit volume registers for main, sub and custom channels
// - volume changes ramp linearly, unity to zero in 512 frames, or 4096 with bit 9 set
// - volume is signed 2.20; negative values invert the channel
// - plus one to minus one ramps through zero in 1024 frame periods, or 8192 with bit 9 set
// - parameter memory 256 words of 22 bits, boot loaded with unity biquads
// - clearing soft mute ramps the volume back to its previous setting
// - power-down stops core clocks without resetting state; only reset pin resets
// - safe transfer copies only safe-load registers written since the last transfer
`timescale 1ns/1ps
module adcr_control_regs
  import adcr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input adcr_req_type host_req,
  output adcr_rsp_type host_rsp,
  output adcr_mode_type mode,
  input wire logic master_clock_source_a,
  input wire logic master_clock_source_b,
  input wire logic master_clock_source_c,
  output logic master_clock_output_pin,
  output logic master_clock_output_oe,
  input wire logic [2:0] serial_source_a,
  input wire logic [2:0] serial_source_b,
  input wire logic [2:0] serial_source_c,
  output logic [2:0] serial_out_pins,
  output logic serial_out_oe,
  output logic core_clock_run,
  output logic boot_busy,
  output logic [VOL_NUM-1:0][21:0] volume_now
);
  // ==========================================================================
  // functions
  function automatic logic [21:0] adcr_boot_word(input logic [7:0] a);
    int i;
    i = int'(a);
    if (i < BIQUAD_WORDS) begin
      return (i % BIQUAD_COEFS == 0) ? VOL_UNITY : 22'h00_0000;
    end
    if ((i >= MAIN_TABLE_LO && i <= MAIN_TABLE_HI) || (i >= SUB_TABLE_LO && i <= SUB_TABLE_HI)
        || i == MAIN_GAIN || i == SUB_GAIN) begin
      return VOL_UNITY;
    end
    if (i == SUB_FEED_L || i == SUB_FEED_R) begin
      return VOL_HALF;
    end
    if (i == HOLD_MAIN || i == HOLD_SUB) begin
      return HOLD_ONE;
    end
    if (i == DECAY_MAIN || i == DECAY_SUB) begin
      return VOL_MAX_INT;
    end
    return 22'h00_0000;
  endfunction : adcr_boot_word

  function automatic logic signed [21:0] adcr_ramp(input logic signed [21:0] cur,
                                                   input logic signed [21:0] tgt,
                                                   input logic [21:0] step);
    logic signed [22:0] diff;
    diff = 23'(tgt) - 23'(cur);
    if (diff > $signed({1'b0, step})) begin
      return 22'(cur + $signed(step));
    end
    if (diff < -$signed({1'b0, step})) begin
      return 22'(cur - $signed(step));
    end
    return tgt;
  endfunction : adcr_ramp

  function automatic logic [2:0] adcr_pick3(input logic [1:0] sel, input logic [2:0] a,
                                            input logic [2:0] b, input logic [2:0] c);
    case (sel)
      2'b00: return a;
      2'b01: return b;
      2'b10: return c;
      default: return 3'b000;
    endcase
  endfunction : adcr_pick3

  // ==========================================================================
  // host decode
  logic [13:0] ctrl1_reg;
  logic [9:0] ctrl2_reg;
  logic wr_ctrl1;
  logic wr_ctrl2;
  logic wr_ram;
  logic rd_req;
  logic rd_status;
  logic safe_start;
  assign wr_ctrl1 = host_req.valid && host_req.write && host_req.addr == ADDR_CTRL1;
  assign wr_ctrl2 = host_req.valid && host_req.write && host_req.addr == ADDR_CTRL2;
  assign wr_ram = host_req.valid && host_req.write && host_req.addr <= ADDR_RAM_LAST;
  assign rd_req = host_req.valid && !host_req.write;
  assign rd_status = rd_req && host_req.addr == ADDR_CTRL1;
  assign safe_start = wr_ctrl1 && host_req.data[C1_SAFE];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl1_reg <= CTRL1_RESET;
    end else if (wr_ctrl1) begin
      ctrl1_reg <= host_req.data[13:0] & CTRL1_MASK;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl2_reg <= CTRL2_RESET;
    end else if (wr_ctrl2) begin
      ctrl2_reg <= host_req.data[9:0] & CTRL2_MASK;
    end
  end

  always_comb begin
    mode.capture = adcr_capture_type'(ctrl1_reg[C1_CAP_LO +: 2]);
    mode.deemph = adcr_deemph_type'(ctrl1_reg[C1_DEEMPH_LO +: 2]);
    mode.format = adcr_format_type'(ctrl1_reg[C1_FMT_LO +: 2]);
    mode.wlen = ctrl1_reg[C1_WLEN_LO + 1] ? WL_16 : adcr_wlen_type'(ctrl1_reg[C1_WLEN_LO +: 2]);
    mode.mute = ctrl1_reg[C1_MUTE];
    mode.powerdown = ctrl1_reg[C1_PDN];
    mode.halt = ctrl1_reg[C1_HALT];
    mode.core_doubler = ctrl2_reg[C2_MCLK_256];
    mode.ramp_slow = ctrl2_reg[C2_RAMP_SLOW];
  end

  // ==========================================================================
  // pin synchronisers and frame tick
  logic [8:0] ser_meta_reg;
  logic [8:0] ser_sync_reg;
  logic [2:0] mclk_meta_reg;
  logic [2:0] mclk_sync_reg;
  logic [2:0] ser_sel;
  logic lrclk_prev_reg;
  logic mclk_prev_reg;
  logic mclk_sel;
  logic [2:0] mclk_pick;
  logic frame_tick;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ser_meta_reg <= 9'h000;
      ser_sync_reg <= 9'h000;
      mclk_meta_reg <= 3'h0;
      mclk_sync_reg <= 3'h0;
    end else begin
      ser_meta_reg <= {serial_source_c, serial_source_b, serial_source_a};
      ser_sync_reg <= ser_meta_reg;
      mclk_meta_reg <= {master_clock_source_c, master_clock_source_b, master_clock_source_a};
      mclk_sync_reg <= mclk_meta_reg;
    end
  end
  // bit 0 data, bit 1 frame clock, bit 2 bit clock
  assign ser_sel = adcr_pick3(ctrl2_reg[C2_SIN_LO +: 2], ser_sync_reg[2:0],
                              ser_sync_reg[5:3], ser_sync_reg[8:6]);
  assign mclk_pick = adcr_pick3(ctrl2_reg[C2_MCLK_LO +: 2], {2'b00, mclk_sync_reg[0]},
                                {2'b00, mclk_sync_reg[1]}, {2'b00, mclk_sync_reg[2]});
  assign mclk_sel = mclk_pick[0];
  assign frame_tick = ser_sel[1] && !lrclk_prev_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lrclk_prev_reg <= 1'b0;
      mclk_prev_reg <= 1'b0;
    end else begin
      lrclk_prev_reg <= ser_sel[1];
      mclk_prev_reg <= mclk_sel;
    end
  end

  // ==========================================================================
  // serial pass-through and clock output
  logic half_reg;
  adcr_mout_type mout;
  assign mout = adcr_mout_type'(ctrl2_reg[C2_MOUT_LO +: 2]);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      serial_out_pins <= 3'b000;
      serial_out_oe <= 1'b0;
    end else begin
      serial_out_pins <= ctrl2_reg[C2_SOUT_EN] ? ser_sel : 3'b000;
      serial_out_oe <= ctrl2_reg[C2_SOUT_EN];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      half_reg <= 1'b0;
    end else if (mclk_sel && !mclk_prev_reg) begin
      half_reg <= !half_reg;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      master_clock_output_pin <= 1'b0;
      master_clock_output_oe <= 1'b0;
    end else begin
      master_clock_output_oe <= mout != MO_OFF;
      case (mout)
        MO_CORE: master_clock_output_pin <= mclk_sel;
        MO_HALF: master_clock_output_pin <= !half_reg;
        MO_THRU: master_clock_output_pin <= mclk_sel;
        default: master_clock_output_pin <= 1'b0;
      endcase
    end
  end

  // ==========================================================================
  // volume registers and ramps
  logic signed [21:0] vol_reg [VOL_NUM];
  logic signed [21:0] vol_cur_reg [VOL_NUM];
  logic [21:0] step;
  logic ramp_down;
  logic all_silent;
  assign step = ctrl2_reg[C2_RAMP_SLOW] ? STEP_SLOW : STEP_FAST;
  assign ramp_down = ctrl1_reg[C1_MUTE] || ctrl1_reg[C1_HALT];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < VOL_NUM; i++) begin
        vol_reg[i] <= VOL_UNITY;
      end
    end else if (host_req.valid && host_req.write && host_req.addr >= ADDR_VOL_FIRST
                 && host_req.addr <= ADDR_VOL_LAST) begin
      vol_reg[3'(host_req.addr - ADDR_VOL_FIRST)] <= host_req.data[21:0];
    end
  end

  // the muted target is zero; the stored setting is kept so unmute returns to it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < VOL_NUM; i++) begin
        vol_cur_reg[i] <= VOL_UNITY;
      end
    end else if (frame_tick) begin
      for (int i = 0; i < VOL_NUM; i++) begin
        vol_cur_reg[i] <= adcr_ramp(vol_cur_reg[i], ramp_down ? 22'sd0 : vol_reg[i],
                                    step);
      end
    end
  end

  always_comb begin
    all_silent = 1'b1;
    for (int i = 0; i < VOL_NUM; i++) begin
      volume_now[i] = vol_cur_reg[i];
      all_silent = all_silent && vol_cur_reg[i] == 22'sd0;
    end
  end

  // ==========================================================================
  // halt and power-down
  logic halt_done_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      halt_done_reg <= 1'b0;
    end else begin
      halt_done_reg <= ctrl1_reg[C1_HALT] && all_silent;
    end
  end
  // gating only; no state is cleared by power-down or halt
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      core_clock_run <= 1'b1;
    end else begin
      core_clock_run <= !ctrl1_reg[C1_PDN] && !halt_done_reg;
    end
  end

  // ==========================================================================
  // parameter memory, boot loader and safe-load
  logic [21:0] pram [PRAM_DEPTH];
  logic [7:0] boot_addr_reg;
  logic [7:0] safe_addr_reg [SAFE_NUM];
  logic [21:0] safe_data_reg [SAFE_NUM];
  logic [SAFE_NUM-1:0] safe_dirty_reg;
  logic [SAFE_NUM-1:0] safe_wr;
  logic [SAFE_NUM-1:0] safe_clr;
  logic safe_pending_reg;
  logic safe_done_evt;
  logic copy_go;
  logic [2:0] copy_idx;
  logic status_safe_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      boot_busy <= 1'b1;
      boot_addr_reg <= 8'h00;
    end else if (boot_busy) begin
      boot_addr_reg <= boot_addr_reg + 8'h01;
      boot_busy <= boot_addr_reg != ADDR_RAM_LAST[7:0];
    end
  end

  always_comb begin
    copy_idx = 3'd0;
    for (int i = SAFE_NUM - 1; i >= 0; i--) begin
      if (safe_dirty_reg[i]) begin
        copy_idx = 3'(i);
      end
    end
    for (int i = 0; i < SAFE_NUM; i++) begin
      safe_wr[i] = host_req.valid && host_req.write && host_req.addr == ADDR_SAFE_FIRST + 10'(i);
    end
  end
  // a host write to memory takes the port, so the copy waits one cycle
  assign copy_go = safe_pending_reg && !boot_busy && !wr_ram && safe_dirty_reg != '0;
  assign safe_clr = copy_go ? SAFE_NUM'(1) << copy_idx : '0;
  assign safe_done_evt = safe_pending_reg && !boot_busy && safe_dirty_reg == '0;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      safe_dirty_reg <= '0;
      for (int i = 0; i < SAFE_NUM; i++) begin
        safe_addr_reg[i] <= 8'h00;
        safe_data_reg[i] <= 22'h00_0000;
      end
    end else begin
      for (int i = 0; i < SAFE_NUM; i++) begin
        if (safe_wr[i]) begin
          safe_addr_reg[i] <= host_req.data[SAFE_ADDR_LO +: 8];
          safe_data_reg[i] <= host_req.data[SAFE_DATA_LO +: 22];
        end
      end
      safe_dirty_reg <= (safe_dirty_reg & ~safe_clr) | safe_wr;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      safe_pending_reg <= 1'b0;
    end else if (safe_start) begin
      safe_pending_reg <= 1'b1;
    end else if (safe_done_evt) begin
      safe_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_safe_reg <= 1'b0;
    end else if (safe_done_evt) begin
      status_safe_reg <= 1'b1;
    end else if (rd_status) begin
      status_safe_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (boot_busy) begin
      pram[boot_addr_reg] <= adcr_boot_word(boot_addr_reg);
    end else if (wr_ram) begin
      pram[host_req.addr[7:0]] <= host_req.data[21:0];
    end else if (copy_go) begin
      pram[safe_addr_reg[copy_idx]] <= safe_data_reg[copy_idx];
    end
  end

  // ==========================================================================
  // read answer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      host_rsp <= '0;
    end else begin
      host_rsp.valid <= rd_req;
      if (!rd_req) begin
        host_rsp.data <= 24'h00_0000;
      end else if (host_req.addr <= ADDR_RAM_LAST) begin
        host_rsp.data <= {2'b00, pram[host_req.addr[7:0]]};
      end else if (host_req.addr == ADDR_CTRL1) begin
        host_rsp.data <= {22'h00_0000, halt_done_reg, status_safe_reg};
      end else begin
        host_rsp.data <= 24'h00_0000;
      end
    end
  end

  // ==========================================================================
  // checks
  a_halt_store: assert property (@(posedge clock) disable iff (rst)
    wr_ctrl1 |=> mode.halt == $past(host_req.data[C1_HALT]))
    else $error("halt bit not stored");
  a_mute_ramp: assert property (@(posedge clock) disable iff (rst)
    frame_tick && ramp_down && vol_cur_reg[7] > $signed(step) && !wr_ctrl2
    |=> vol_cur_reg[7] == $past(vol_cur_reg[7]) - $signed($past(step)))
    else $error("mute ramp step wrong");
  a_safe_done: assert property (@(posedge clock) disable iff (rst)
    safe_pending_reg && !boot_busy && safe_dirty_reg == '0 |=> status_safe_reg)
    else $error("safe-load completion not flagged");
  a_status_clear: assert property (@(posedge clock) disable iff (rst)
    rd_status && !safe_done_evt |=> !status_safe_reg)
    else $error("status not cleared by read");
  a_halt_status: assert property (@(posedge clock) disable iff (rst)
    $rose(halt_done_reg) |-> $past(mode.halt) && $past(all_silent))
    else $error("halt done without silence");
  a_sout_gate: assert property (@(posedge clock) disable iff (rst)
    !ctrl2_reg[C2_SOUT_EN] |=> !serial_out_oe && serial_out_pins == 3'b000)
    else $error("serial out driven while disabled");
  a_mclk_off: assert property (@(posedge clock) disable iff (rst)
    mout == MO_OFF |=> !master_clock_output_oe && !master_clock_output_pin)
    else $error("clock output driven while off");
  a_boot_end: assert property (@(posedge clock) disable iff (rst)
    boot_busy && boot_addr_reg == ADDR_RAM_LAST[7:0] |=> !boot_busy ##1 !boot_busy)
    else $error("boot did not end after last word");
  a_pdn_stop: assert property (@(posedge clock) disable iff (rst)
    mode.powerdown ##1 mode.powerdown |-> !core_clock_run)
    else $error("core clock runs in power-down");
  a_read_answer: assert property (@(posedge clock) disable iff (rst)
    rd_req |=> host_rsp.valid ##1 ($past(rd_req) || !host_rsp.valid))
    else $error("read answer timing wrong");
endmodule : adcr_control_regs

//--- testbench/adcr_host_model.sv
// host model issuing word requests on the control port
`timescale 1ns/1ps
module adcr_host_model
  import adcr_pkg::*;
(
  input wire logic clock,
  input adcr_rsp_type host_rsp,
  output adcr_req_type host_req
);
  initial host_req = '0;
  task automatic wr(input logic [9:0] a, input logic [29:0] d);
    @(negedge clock);
    host_req = '{valid: 1'b1, write: 1'b1, addr: a, data: d};
    @(negedge clock);
    host_req = '0;
  endtask : wr
  task automatic rd(input logic [9:0] a, output logic [23:0] d);
    @(negedge clock);
    host_req = '{valid: 1'b1, write: 1'b0, addr: a, data: 30'h0000_0000};
    @(negedge clock);
    host_req = '0;
    if (host_rsp.valid !== 1'b1) @(negedge clock);
    d = host_rsp.data;
  endtask : rd
endmodule : adcr_host_model

//--- testbench/adcr_control_regs_tb_top.sv
// self-checking bench of the control register block
`timescale 1ns/1ps
module adcr_control_regs_tb_top;
  import adcr_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] fcnt = 8'h00;
  logic [2:0] src_a;
  adcr_req_type host_req;
  adcr_rsp_type host_rsp;
  adcr_mode_type mode;
  logic mclk_oe, sout_oe, core_run, boot_busy, mclk_pin;
  logic [2:0] sout;
  logic [VOL_NUM-1:0][21:0] vol;
  logic [23:0] rdat;
  int failures = 0;
  int samples_checked = 0;
  always #5 clock = ~clock;
  // frame clock on bit1 runs at one period per 16 cycles
  always @(negedge clock) fcnt <= fcnt + 8'h01;
  assign src_a = {fcnt[2], fcnt[3], fcnt[4]};
  adcr_host_model adcr_host_model_inst (.clock(clock), .host_rsp(host_rsp), .host_req(host_req));
  adcr_control_regs adcr_control_regs_inst (
    .clock(clock), .rst(rst), .host_req(host_req), .host_rsp(host_rsp), .mode(mode),
    .master_clock_source_a(fcnt[1]), .master_clock_source_b(1'b0),
    .master_clock_source_c(1'b0), .master_clock_output_pin(mclk_pin),
    .master_clock_output_oe(mclk_oe), .serial_source_a(src_a), .serial_source_b(3'b101),
    .serial_source_c(3'b010), .serial_out_pins(sout), .serial_out_oe(sout_oe),
    .core_clock_run(core_run), .boot_busy(boot_busy), .volume_now(vol));
  // ==========================================================================
  // helpers
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic rchk(input logic [9:0] a, input logic [23:0] exp);
    adcr_host_model_inst.rd(a, rdat);
    check(rdat, exp);
  endtask : rchk
  // rising edges of the clock output pin over 16 cycles
  task automatic clock_edges(input int exp);
    int n;
    logic last;
    n = 0;
    last = mclk_pin;
    repeat (16) begin
      @(negedge clock);
      if (mclk_pin && !last) n++;
      last = mclk_pin;
    end
    check(24'(n), 24'(exp));
  endtask : clock_edges
  task automatic frames(input int n);
    repeat (n * 16) @(negedge clock);
  endtask : frames
  task automatic test_done;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  // ==========================================================================
  // scenarios
  task automatic t_boot;
    check({2'h0, vol[7]}, 24'h10_0000);
    check({21'h0, core_run, mclk_oe, sout_oe}, 24'h4);
    for (int i = 0; i < 400 && boot_busy !== 1'b0; i++) @(negedge clock);
    rchk(10'h000, 24'h10_0000);
    rchk(10'h004, 24'h00_0000);
    rchk(10'h06E, 24'h10_0000);
    rchk(10'h0C1, 24'h3F_FFFF);
    $display("t_boot done");
  endtask : t_boot
  task automatic t_ctrl1;
    logic [1:0] w;
    for (int i = 0; i < 4; i++) begin
      w = (i == 3) ? 2'b10 : 2'(i);
      adcr_host_model_inst.wr(ADDR_CTRL1, {16'h0, 2'(i), 4'b1001, 2'b00, 2'(i), 2'(i), 2'(i)});
      @(negedge clock);
      check({13'h0, mode.mute, mode.powerdown, mode.halt, mode.capture, mode.deemph,
        mode.format, mode.wlen}, {16'h0, 2'(i), 2'(i), 2'(i), w});
    end
    adcr_host_model_inst.wr(ADDR_CTRL1, 30'h0000_0040);
    repeat (3) @(negedge clock);
    check({22'h0, mode.powerdown, core_run}, 24'h2);
    adcr_host_model_inst.wr(ADDR_CTRL1, 30'h0000_0000);
    $display("t_ctrl1 done");
  endtask : t_ctrl1
  task automatic t_vol;
    adcr_host_model_inst.wr(ADDR_VOL_FIRST, 30'h0000_0000);
    adcr_host_model_inst.wr(ADDR_VOL_FIRST + 10'h001, 30'h0030_0000);
    frames(500);
    check({23'h0, vol[0] != 22'h0}, 24'h1);
    frames(20);
    check({2'h0, vol[0]}, 24'h0);
    frames(480);
    check({22'h0, vol[1][21], vol[1] != 22'h30_0000}, 24'h3);
    frames(30);
    check({2'h0, vol[1]}, 24'h30_0000);
    adcr_host_model_inst.wr(ADDR_CTRL2, 30'h0000_0200);
    check({22'h0, mode.core_doubler, mode.ramp_slow}, 24'h1);
    adcr_host_model_inst.wr(ADDR_VOL_FIRST + 10'h002, 30'h0000_0000);
    frames(520);
    check({23'h0, vol[2] > 22'h0C_0000}, 24'h1);
    adcr_host_model_inst.wr(ADDR_CTRL2, 30'h0000_0000);
    $display("t_vol done");
  endtask : t_vol
  task automatic t_halt;
    adcr_host_model_inst.wr(ADDR_CTRL1, 30'h0000_0480);
    frames(530);
    rchk(ADDR_CTRL1, 24'h2);
    check({1'b0, core_run, vol[7]}, 24'h0);
    // selections change only while the core is shut down
    adcr_host_model_inst.wr(ADDR_CTRL2, 30'h0000_014B);
    repeat (5) @(negedge clock);
    check({19'h0, mclk_oe, sout_oe, sout}, 24'h1D);
    clock_edges(4);
    // back to the first serial source so frame ticks resume for the ramp up
    adcr_host_model_inst.wr(ADDR_CTRL2, 30'h0000_0006);
    repeat (4) @(negedge clock);
    check({22'h0, mode.core_doubler, mode.ramp_slow}, 24'h2);
    clock_edges(2);
    adcr_host_model_inst.wr(ADDR_CTRL1, 30'h0000_0000);
    frames(530);
    check({1'b0, core_run, vol[7]}, 24'h50_0000);
    $display("t_halt done");
  endtask : t_halt
  task automatic t_safe;
    adcr_host_model_inst.wr(ADDR_SAFE_FIRST, {8'h05, 22'h12_3456});
    adcr_host_model_inst.wr(ADDR_CTRL1, 30'h0000_0200);
    repeat (10) @(negedge clock);
    rchk(ADDR_CTRL1, 24'h1);
    rchk(ADDR_CTRL1, 24'h0);
    rchk(10'h005, 24'h12_3456);
    adcr_host_model_inst.wr(10'h005, 30'h0000_0001);
    adcr_host_model_inst.wr(ADDR_CTRL1, 30'h0000_0200);
    repeat (10) @(negedge clock);
    rchk(10'h005, 24'h1);
    $display("t_safe done");
  endtask : t_safe
  initial begin
    repeat (20) @(negedge clock);
    rst = 1'b0;
    t_boot;
    t_ctrl1;
    t_vol;
    t_halt;
    t_safe;
    test_done;
  end
  initial begin
    repeat (90000) @(negedge clock);
    failures++;
    test_done;
  end
endmodule : adcr_control_regs_tb_top
